// file: src/isr_defines.svh
// Register offsets, field positions, reset values and timing counts of the sensor readout
`ifndef ISR_DEFINES_SVH
`define ISR_DEFINES_SVH
`define ISR_ARRAY_SIZE        12'd2047
`define ISR_COLS_PER_CH       7'd127
`define ISR_CH_MAX            5'd16
`define ISR_SPI_ADDR_W        7
`define ISR_REG_TEMP_LOW      7'h7e
`define ISR_REG_TEMP_HIGH     7'h7f
`define ISR_REG_MODE          7'h01
`define ISR_REG_OFFSET        7'h02
`define ISR_REG_GAIN          7'h03
`define ISR_REG_FRAMES        7'h04
`define ISR_REG_WIN_BASE      7'h10
`define ISR_MODE_RES12_BIT    0
`define ISR_MODE_CHSEL_LO     1
`define ISR_MODE_MIRX_BIT     3
`define ISR_MODE_MIRY_BIT     4
`define ISR_MODE_RESET        8'h00
`define ISR_FRAMES_RESET      8'h01
`define ISR_WIN_COUNT         8
`define ISR_BIT_RATE_MBPS     480
`define ISR_CLK_MHZ           25
`define ISR_BIT_DIV           4'((`ISR_CLK_MHZ * 2 + `ISR_BIT_RATE_MBPS - 1) / `ISR_BIT_RATE_MBPS)
`define ISR_FIFO_DEPTH        16
`endif

// file: src/isr_fifo.sv
// Parameterised valid/ready FIFO for the pixel word path
module isr_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rstn,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];    // Storage
	logic [AW-1:0]    wr_ptr;         // Write pointer
	logic [AW-1:0]    rd_ptr;         // Read pointer
	logic [AW:0]      count;          // Fill level
	logic             push;
	logic             pop;

	assign in_ready  = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem[rd_ptr];

	// Storage write
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Pointers and level
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + AW'(1);
			end
			if (pop) begin
				rd_ptr <= rd_ptr + AW'(1);
			end
			if (push && !pop) begin
				count <= count + (AW+1)'(1);
			end else if (pop && !push) begin
				count <= count - (AW+1)'(1);
			end
		end
	end
endmodule : isr_fifo

// file: src/isr_pkg.sv
// Types shared by the sensor readout modules
package isr_pkg;
	typedef enum logic [1:0] {
		ISR_CH16,
		ISR_CH8,
		ISR_CH4,
		ISR_CH2
	} isr_chsel_t;
	typedef struct packed {
		logic [11:0] row;
		logic [11:0] col;
		logic [11:0] pix;
	} isr_word_t;
	typedef struct packed {
		logic dval;
		logic lval;
		logic fval;
	} isr_ctrl_t;
endpackage : isr_pkg

// file: src/isr_readout.sv
// Sensor readout sequencer: frame capture, row scan, serial lanes, SPI register port
`include "isr_defines.svh"

// Notes on behaviour
// - Global capture, then rows read in sequence
// - Each lane carries 128 adjacent columns in sixteen-lane mode
// - Sixteen data, one control, one clock output
// - Words serialised as 10 or 12 bits
// - DDR clock aligned with data lanes
// - Control lane flags data word validity
// - Lane bit rate at most 480 Mbps
// - Sixteen, eight, four or two lanes
// - Temperature read at 126 and 127 burst
// - Registers written and read over SPI
// - Programmable offset added; gain register
// - Up to eight row windows
// - Horizontal and vertical mirroring selectable
// - Sequencer held reset while reset low
// - Frame request starts programmed frame count
module isr_readout
	import isr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rstn,
	// Sensor control pins
	input  wire logic        system_reset_low,
	input  wire logic        frame_req,
	// Pixel and temperature sources
	input  wire logic [11:0] adc_value,
	input  wire logic [15:0] temp_value,
	// SPI register port
	input  wire logic        spi_clk,
	input  wire logic        spi_en,
	input  wire logic        spi_in,
	output logic             spi_out,
	// Serial outputs
	output logic [15:0]      lane_data,
	output logic             lane_ctrl,
	output logic             lane_clk,
	// Pixel position being converted
	output logic [11:0]      pix_row,
	output logic [11:0]      pix_col
);
	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CAPTURE,
		ST_READ,
		ST_NEXT
	} isr_state_t;

	// Synchronisers for pins
	logic [1:0]  sync_rst;                   // Sequencer reset pin
	logic [1:0]  sync_req;                   // Frame request pin
	logic [1:0]  sync_sclk;                  // SPI clock
	logic [1:0]  sync_sen;                   // SPI enable
	logic [1:0]  sync_sin;                   // SPI data
	logic        sclk_d;                     // Delayed SPI clock
	logic        seq_rst;                    // Sequencer reset, active
	// Registers
	logic [7:0]  mode;                       // Resolution, lanes, mirroring
	logic [7:0]  offset;                     // Digital offset
	logic [7:0]  gain;                       // Analog gain code
	logic [7:0]  frames;                     // Frames per request
	logic [7:0]  win_start [`ISR_WIN_COUNT]; // Window start row / 8
	logic [7:0]  win_len   [`ISR_WIN_COUNT]; // Window length / 8, zero off
	// SPI engine
	logic [4:0]  spi_cnt;                    // Bit count in byte pair
	logic [15:0] spi_sh;                     // Shift register
	logic [6:0]  spi_addr;                   // Current address
	logic        spi_wr;                     // Write transaction
	logic [15:0] temp_snap;                  // Temperature frozen for burst
	logic [7:0]  rd_byte;                    // Addressed register value
	// Sequencer
	isr_state_t  state;
	logic [7:0]  frame_left;                 // Frames still to send
	logic [11:0] row;                        // Row counter
	logic [11:0] col;                        // Column within the row
	logic        row_in_win;                 // Row belongs to a window
	// Serialiser
	logic [3:0]  div_cnt;                    // Bit rate divider
	logic        bit_en;                     // Bit enable pulse
	logic [3:0]  bit_idx;                    // Bit within word
	logic [3:0]  word_bits;                  // Word width minus one
	logic [11:0] shreg;                      // Word being sent
	logic [3:0]  shlane;                     // Lane of word being sent
	// FIFO handshake and words
	logic        fifo_in_ready;
	logic        fifo_out_valid;
	isr_word_t   fifo_in;
	isr_word_t   fifo_out;
	logic        sending;                    // Word on lanes is valid
	logic [4:0]  lanes;                      // Active lane count
	logic [12:0] next_pix;                   // Offset sum

	// Pin synchronisers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			// All pins read as low until sampled
			sync_rst  <= 2'h0;
			sync_req  <= 2'h0;
			sync_sclk <= 2'h0;
			sync_sen  <= 2'h0;
			sync_sin  <= 2'h0;
			sclk_d    <= 1'b0;
		end else begin
			// Shift each pin through its two flops
			sync_rst  <= {sync_rst[0], system_reset_low};
			sync_req  <= {sync_req[0], frame_req};
			sync_sclk <= {sync_sclk[0], spi_clk};
			sync_sen  <= {sync_sen[0], spi_en};
			sync_sin  <= {sync_sin[0], spi_in};
			// SPI clock edges found against this delayed copy
			sclk_d    <= sync_sclk[1];
		end
	end

	// Sequencer reset follows the synchronised pin, active low
	assign seq_rst = !sync_rst[1];

	// Register read mux
	// Read data comes from the current address: the command byte's, stepped after each data byte
	always_comb begin
		// Unmapped addresses read as zero
		rd_byte = 8'h00;
		case (spi_addr)
			`ISR_REG_MODE:      rd_byte = mode;
			`ISR_REG_OFFSET:    rd_byte = offset;
			`ISR_REG_GAIN:      rd_byte = gain;
			`ISR_REG_FRAMES:    rd_byte = frames;
			`ISR_REG_TEMP_LOW:  rd_byte = temp_snap[7:0];
			`ISR_REG_TEMP_HIGH: rd_byte = temp_snap[15:8];
			default: begin
				// Window registers: upper half lengths, lower half starts
				if (spi_addr[6:4] == 3'h1) begin
					rd_byte = spi_addr[3] ? win_len[spi_addr[2:0]] : win_start[spi_addr[2:0]];
				end
			end
		endcase
	end

	// Temperature tracks while the port is idle and is frozen during a transaction, so a burst reads one sample
	// SPI frame: wr bit, 7 address bits, then data bytes; address steps each byte
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			spi_cnt   <= 5'h00;
			spi_sh    <= 16'h0000;
			spi_addr  <= 7'h00;
			spi_wr    <= 1'b0;
			spi_out   <= 1'b0;
			temp_snap <= 16'h0000;
			mode      <= `ISR_MODE_RESET;
			offset    <= 8'h00;
			gain      <= 8'h00;
			frames    <= `ISR_FRAMES_RESET;
			for (int i = 0; i < `ISR_WIN_COUNT; i++) begin
				win_start[i] <= 8'h00;
				win_len[i]   <= 8'h00;
			end
			// Window 0 is open after reset
			win_len[0] <= 8'hff;
		end else if (!sync_sen[1]) begin
			// Idle between transactions: restart the count, track temperature
			spi_cnt   <= 5'h00;
			temp_snap <= temp_value;
		end else if (sync_sclk[1] && !sclk_d) begin
			spi_sh <= {spi_sh[14:0], sync_sin[1]};
			if (spi_cnt == 5'h07) begin
				// Command byte complete: latch direction and start address
				spi_wr   <= spi_sh[6];
				spi_addr <= {spi_sh[5:0], sync_sin[1]};
				spi_cnt  <= 5'h08;
			end else if (spi_cnt == 5'h0f) begin
				// Data byte complete: step address for burst, store on write
				spi_cnt  <= 5'h08;
				spi_addr <= spi_addr + 7'h01;
				if (spi_wr) begin
					case (spi_addr)
						`ISR_REG_MODE:   mode   <= {spi_sh[6:0], sync_sin[1]};
						`ISR_REG_OFFSET: offset <= {spi_sh[6:0], sync_sin[1]};
						`ISR_REG_GAIN:   gain   <= {spi_sh[6:0], sync_sin[1]};
						`ISR_REG_FRAMES: frames <= {spi_sh[6:0], sync_sin[1]};
						default: begin
							// Writes to read-only or unmapped addresses are dropped
							if (spi_addr[6:4] == 3'h1 && spi_addr[3]) begin
								win_len[spi_addr[2:0]] <= {spi_sh[6:0], sync_sin[1]};
							end else if (spi_addr[6:4] == 3'h1) begin
								win_start[spi_addr[2:0]] <= {spi_sh[6:0], sync_sin[1]};
							end
						end
					endcase
				end
			end else begin
				// Count bits within the current byte
				spi_cnt <= spi_cnt + 5'h01;
			end
		end else if (!sync_sclk[1] && sclk_d && spi_cnt >= 5'h08 && !spi_wr) begin
			// Read data changes after the falling edge, held until the next
			spi_out <= rd_byte[3'(5'h0f - spi_cnt)];
		end
	end

	// Row window membership
	// A row is read when any enabled window covers it
	always_comb begin
		row_in_win = 1'b0;
		for (int i = 0; i < `ISR_WIN_COUNT; i++) begin
			// Bounds compare in units of eight rows
			if (win_len[i] != 8'h00 && row[11:3] >= {1'b0, win_start[i]}
				&& row[11:3] < ({1'b0, win_start[i]} + {1'b0, win_len[i]})) begin
				row_in_win = 1'b1;
			end
		end
	end

	// Sequencer state machine
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			// Start idle with counters at the first pixel
			state      <= ST_IDLE;
			frame_left <= 8'h00;
			row        <= 12'h000;
			col        <= 12'h000;
		end else if (seq_rst) begin
			// Pin reset parks the sequencer; registers keep their values
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					// Wait for a request with a non-zero frame count
					if (sync_req[1] && frames != 8'h00) begin
						frame_left <= frames;
						state      <= ST_CAPTURE;
					end
				end
				ST_CAPTURE: begin
					// Whole array was exposed at once; start from the top row
					row   <= 12'h000;
					col   <= 12'h000;
					state <= ST_READ;
				end
				ST_READ: begin
					// Rows outside every window are skipped without output
					if (!row_in_win) begin
						state <= ST_NEXT;
					end else if (fifo_in_ready) begin
						// Stall on a full FIFO so no pixel is lost; the row spans the array
						if (col == `ISR_ARRAY_SIZE) begin
							state <= ST_NEXT;
						end
						col <= col + 12'h001;
					end
				end
				ST_NEXT: begin
					// Row done: count a frame at the bottom, else step down
					col <= 12'h000;
					if (row == `ISR_ARRAY_SIZE) begin
						frame_left <= frame_left - 8'h01;
						state      <= (frame_left == 8'h01) ? ST_IDLE : ST_CAPTURE;
					end else begin
						row   <= row + 12'h001;
						state <= ST_READ;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Mirroring maps scan position to array position
	assign pix_row  = mode[`ISR_MODE_MIRY_BIT] ? (`ISR_ARRAY_SIZE - row) : row;
	assign pix_col  = mode[`ISR_MODE_MIRX_BIT] ? (`ISR_ARRAY_SIZE - col) : col;
	// Offset sum saturates rather than wrapping to dark
	assign next_pix = {1'b0, adc_value} + {5'h00, offset};
	assign fifo_in  = '{row: pix_row, col: pix_col,
		pix: next_pix[12] ? 12'hfff : next_pix[11:0]};

	// FIFO decouples the row scan from the slower serial output
	isr_fifo #(
		.WIDTH ($bits(isr_word_t)),
		.DEPTH (`ISR_FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rstn      (rstn),
		.in_valid  (state == ST_READ && row_in_win),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (fifo_out_valid),
		.out_ready (bit_en && bit_idx == 4'h0),
		.out_data  (fifo_out)
	);

	// Bit enable divider
	// With the system clock below half the lane limit the divider is one
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			div_cnt <= 4'h0;
		end else if (div_cnt == `ISR_BIT_DIV - 4'h1) begin
			div_cnt <= 4'h0;
		end else begin
			div_cnt <= div_cnt + 4'h1;
		end
	end

	// Bit pulse from the divider; word width and active lane count from the mode register
	assign bit_en    = (div_cnt == 4'h0);
	assign word_bits = mode[`ISR_MODE_RES12_BIT] ? 4'hb : 4'h9;
	assign lanes     = `ISR_CH_MAX >> mode[`ISR_MODE_CHSEL_LO +: 2];

	// Serialiser; fewer lanes means the unused lanes idle low
	// A word is taken from the FIFO when the previous word's last bit leaves
	// The lane number is latched with the word, since the FIFO head moves on
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			// Lanes, control and clock start low
			bit_idx   <= 4'h0;
			shreg     <= 12'h000;
			shlane    <= 4'h0;
			sending   <= 1'b0;
			lane_data <= 16'h0000;
			lane_ctrl <= 1'b0;
			lane_clk  <= 1'b0;
		end else if (bit_en) begin
			// Clock toggles once per bit, so each edge carries one bit
			lane_clk <= !lane_clk;
			if (bit_idx == 4'h0) begin
				// Load the next word, or an idle slot when the FIFO is empty
				sending <= fifo_out_valid;
				shreg   <= fifo_out_valid ? fifo_out.pix : 12'h000;
				// Group of 128 columns per lane; fewer lanes take neighbouring groups
				shlane  <= fifo_out_valid ? 4'(fifo_out.col[10:7] >> mode[`ISR_MODE_CHSEL_LO +: 2]) : 4'h0;
				bit_idx <= word_bits;
			end else begin
				// Shift towards the top bit, most significant bit first
				bit_idx <= bit_idx - 4'h1;
				shreg   <= {shreg[10:0], 1'b0};
			end
			// Only the lane that owns the word shows its bits
			for (int i = 0; i < 16; i++) begin
				lane_data[i] <= (5'(i) < lanes) && (4'(i) == shlane) && shreg[word_bits];
			end
			// Valid flag lags the load by one bit, like the data
			lane_ctrl <= sending;
		end
	end
endmodule : isr_readout

// file: tb/isr_grabber.sv
// Frame grabber model: takes lane 0 bits on both lane clock edges
module isr_grabber (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	// Lanes
	input wire logic [15:0] lane_data,
	input wire logic        lane_ctrl,
	input wire logic        lane_clk,
	// Results
	output int              nbits,
	output logic [11:0]     word0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last_clk; // Lane clock one cycle ago
	// Each lane clock change is one bit, rising or falling
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			nbits <= 0;
			word0 <= 12'h000;
			last_clk <= 1'b0;
		end else begin
			last_clk <= lane_clk;
			if (lane_clk != last_clk && lane_ctrl) begin
				nbits <= nbits + 1;
				if (nbits < 12)
					word0 <= {word0[10:0], lane_data[0]};
			end
		end
	end
endmodule : isr_grabber

// file: tb/isr_readout_bench.sv
// Self-checking bench for the sensor readout
`include "isr_defines.svh"
module isr_readout_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 0, rstn = 0, srl = 1, frame_req = 0;
	logic spi_clk = 0, spi_en = 0, spi_in = 0, spi_out, lane_ctrl, lane_clk;
	logic [11:0] adc_value = 12'h5a3, pix_row, pix_col, word0;
	logic [15:0] temp_value = 16'h0000, lane_data, rd;
	int fail_count = 0, cmp_count = 0, nbits;
	always #20 clk_sys = ~clk_sys;
	isr_readout uut (.clk_sys(clk_sys), .rstn(rstn), .system_reset_low(srl), .frame_req(frame_req),
		.adc_value(adc_value), .temp_value(temp_value), .spi_clk(spi_clk), .spi_en(spi_en), .spi_in(spi_in),
		.spi_out(spi_out), .lane_data(lane_data), .lane_ctrl(lane_ctrl), .lane_clk(lane_clk),
		.pix_row(pix_row), .pix_col(pix_col));
	isr_grabber u_grab (.clk_sys(clk_sys), .rstn(rstn), .lane_data(lane_data), .lane_ctrl(lane_ctrl),
		.lane_clk(lane_clk), .nbits(nbits), .word0(word0));
	task automatic check(input string n, input logic [15:0] e, input logic [15:0] s);
		cmp_count++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
			fail_count++;
		end
	endtask : check
	task automatic test_done();
		if (fail_count == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done
	// One SPI bit: data after the fall, read bit taken at the rise; four clocks a phase
	task automatic spi_bit(input logic b, inout logic [15:0] r);
		@(posedge clk_sys) spi_in <= b;
		spi_clk <= 1'b0;
		repeat (4) @(posedge clk_sys);
		r = {r[14:0], spi_out};
		spi_clk <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask : spi_bit
	// Whole transaction: flag, address, nb data bytes; only data bits land in rd
	task automatic spi(input logic w, input logic [6:0] a, input logic [15:0] wd, input int nb);
		logic [15:0] junk;
		junk = 16'h0000;
		rd = 16'h0000;
		@(posedge clk_sys) spi_en <= 1'b1;
		spi_bit(w, junk);
		for (int i = 6; i >= 0; i--) spi_bit(a[i], junk);
		for (int i = nb * 8 - 1; i >= 0; i--) spi_bit(wd[i], rd);
		@(posedge clk_sys) spi_en <= 1'b0;
		spi_clk <= 1'b0;
		repeat (8) @(posedge clk_sys);
	endtask : spi
	// Reset values, write and read back, unmapped read
	task automatic test_regs();
		spi(1'b0, `ISR_REG_MODE, 16'h0000, 1);
		check("mode", {8'h00, `ISR_MODE_RESET}, rd);
		spi(1'b0, `ISR_REG_FRAMES, 16'h0000, 1);
		check("frames", {8'h00, `ISR_FRAMES_RESET}, rd);
		spi(1'b1, `ISR_REG_OFFSET, 16'h0010, 1);
		spi(1'b0, `ISR_REG_OFFSET, 16'h0000, 1);
		check("offset", 16'h0010, rd);
		spi(1'b0, 7'h60, 16'h0000, 1);
		check("unmapped", 16'h0000, rd);
	endtask : test_regs
	// Temperature by burst, low byte first; write ignored
	task automatic test_temp();
		temp_value <= 16'hb2c4;
		spi(1'b0, `ISR_REG_TEMP_LOW, 16'h0000, 2);
		check("temp", 16'hb2c4, {rd[7:0], rd[15:8]});
		spi(1'b1, `ISR_REG_TEMP_LOW, 16'h0000, 1);
		spi(1'b0, `ISR_REG_TEMP_LOW, 16'h0000, 1);
		check("temp_ro", 16'h00c4, rd);
	endtask : test_temp
	// Request while sequencer held must send nothing
	task automatic test_hold();
		@(posedge clk_sys) srl <= 1'b0;
		repeat (4) @(posedge clk_sys);
		frame_req <= 1'b1;
		repeat (4) @(posedge clk_sys);
		frame_req <= 1'b0;
		repeat (200) @(posedge clk_sys);
		check("held", 16'h0000, 16'(nbits));
		srl <= 1'b1;
		repeat (4) @(posedge clk_sys);
	endtask : test_hold
	// 12-bit frame on one window; first word carries pixel plus offset
	task automatic test_frame();
		int n;
		spi(1'b1, `ISR_REG_MODE, 16'h0018, 1);
		check("mirror_row", 16'h07ff, {4'h0, pix_row});
		check("mirror_col", 16'h07ff, {4'h0, pix_col});
		spi(1'b1, `ISR_REG_MODE, 16'h0001, 1);
		spi(1'b1, 7'h18, 16'h0001, 1);
		@(posedge clk_sys) frame_req <= 1'b1;
		repeat (2) @(posedge clk_sys);
		frame_req <= 1'b0;
		for (n = 0; n < 60000 && nbits < 12; n++) @(posedge clk_sys);
		check("frame_bits", 16'h0001, 16'(nbits >= 12));
		check("word", 16'h05b3, {4'h0, word0});
		if (nbits < 12)
			test_done();
	endtask : test_frame
	initial begin
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (3) @(posedge clk_sys);
		test_regs();
		test_temp();
		test_hold();
		test_frame();
		test_done();
	end
endmodule : isr_readout_bench

// file: tb/isr_readout_monitor.sv
// Port-level checker for the sensor readout
module isr_readout_mon
	import isr_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rstn,
	// Control and SPI pins
	input wire logic        system_reset_low,
	input wire logic        frame_req,
	input wire logic        spi_clk,
	input wire logic        spi_en,
	input wire logic        spi_out,
	// Lanes and position
	input wire logic [15:0] lane_data,
	input wire logic        lane_ctrl,
	input wire logic        lane_clk,
	input wire logic [11:0] pix_row,
	input wire logic [11:0] pix_col
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic seen_req; // Some frame request seen
	// Remember any frame request since reset
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			seen_req <= 1'b0;
		else if (frame_req)
			seen_req <= 1'b1;
	end
	property p_seq_idle; (!system_reset_low)[*8] |-> !lane_ctrl; endproperty
	property p_seq_still; (!system_reset_low)[*6] |-> $stable(pix_row) && $stable(pix_col); endproperty
	property p_ddr_toggle; lane_ctrl |-> lane_clk != $past(lane_clk); endproperty
	property p_data_clk; $changed(lane_data) |-> $changed(lane_clk); endproperty
	property p_word_len; $rose(lane_ctrl) |=> lane_ctrl[*8]; endproperty
	property p_valid_req; lane_ctrl |-> seen_req; endproperty
	property p_spi_hold; $rose(spi_clk) && spi_en |=> $stable(spi_out)[*3]; endproperty
	property p_pix_range; pix_row <= 12'h7ff && pix_col <= 12'h7ff; endproperty
	a_seq_idle: assert property (p_seq_idle) else $error("lane valid while held");
	a_seq_still: assert property (p_seq_still) else $error("position moved while held");
	a_ddr_toggle: assert property (p_ddr_toggle) else $error("lane clock not toggling");
	a_data_clk: assert property (p_data_clk) else $error("lane data off clock");
	a_word_len: assert property (p_word_len) else $error("valid word too short");
	a_valid_req: assert property (p_valid_req) else $error("valid without request");
	a_spi_hold: assert property (p_spi_hold) else $error("read bit moved");
	a_pix_range: assert property (p_pix_range) else $error("position out of array");
	c_frame: cover property ($rose(lane_ctrl));
	c_spi: cover property ($fell(spi_en));
	c_held: cover property ((!system_reset_low)[*8]);
endmodule : isr_readout_mon

bind isr_readout isr_readout_mon u_mon (.clk_sys(clk_sys), .rstn(rstn), .system_reset_low(system_reset_low),
	.frame_req(frame_req), .spi_clk(spi_clk), .spi_en(spi_en), .spi_out(spi_out), .lane_data(lane_data),
	.lane_ctrl(lane_ctrl), .lane_clk(lane_clk), .pix_row(pix_row), .pix_col(pix_col));
